// *** rtl/secmon_top.sv ***
// Security monitor: detector logging and reaction, access trapping, memory
// protection partitions, boot source, flash write guard and lifecycle lock.
// Assumes an AXI4-Lite master with awprot[0]/arprot[0] marking privilege,
// and detector, access and test inputs synchronous to i_clk_sys.
`timescale 1ns/1ns
module secmon_top
    import secmon_pkg::*;
#(
    // Value is arbitrary; production parts load their own secret
    parameter logic [31:0] TEST_PASSWORD = 32'h5EC0_0A11
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // Register bus
    input wire secmon_axi_req_type i_axi,
    output secmon_axi_rsp_type o_axi,
    // Detectors: true and complementary rails, shield alarm
    input wire logic [DET_N-1:0] i_det,
    input wire logic [DET_N-1:0] i_det_n,
    input wire logic i_shield_alarm,
    // External pads
    input wire logic i_rst_pad_n,
    input wire logic i_clk_pad,
    output logic o_rst_pad_filt_n,
    output logic o_clk_pad_filt,
    // Memory access check
    input wire secmon_acc_req_type i_acc,
    output secmon_acc_rsp_type o_acc,
    // Lifecycle and test port
    input wire logic i_nv_normal,
    input wire secmon_test_req_type i_test,
    output logic o_nv_normal_wr,
    output logic o_test_mode,
    output logic o_functest_en,
    output logic o_test_rej,
    // Reactions and boot
    output logic o_chip_reset,
    output logic o_halt_irq,
    output logic o_boot_flash
);

    typedef struct packed {
        logic [1:0] ctrl;
        logic [ST_W-1:0] stat;
        logic boot_flash;
        logic boot_lock;
        logic [2*PART_N-1:0] attr;
        logic [PART_N-1:0][31:0] base;
        logic [PART_N-1:0][31:0] limit;
        secmon_lc_type lc;
        logic aw_got;
        logic [31:0] aw_addr;
        logic aw_priv;
        logic w_got;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        secmon_acc_rsp_type acc;
        logic [RST_CNT_W-1:0] rst_cnt;
        logic halt;
        logic test_rej;
        logic nv_wr;
    } secmon_st_type;

    // Power-on values of every register
    localparam secmon_st_type ST_RST = '{
        ctrl: CTRL_RST, stat: STAT_RST, boot_flash: 1'b0, boot_lock: 1'b0,
        attr: ATTR_RST, base: {PART_N{PART_RST}}, limit: {PART_N{PART_RST}},
        lc: LC_LOAD, aw_got: 1'b0, aw_addr: 32'h0000_0000, aw_priv: 1'b0,
        w_got: 1'b0, wdata: 32'h0000_0000, wstrb: 4'h0, bvalid: 1'b0,
        bresp: RESP_OKAY, rvalid: 1'b0, rdata: 32'h0000_0000, rresp: RESP_OKAY,
        acc: '{done: 1'b0, ok: 1'b0, trap: 1'b0, inval: 1'b0},
        rst_cnt: '0, halt: 1'b0, test_rej: 1'b0, nv_wr: 1'b0
    };

    secmon_st_type st_r;
    secmon_st_type st_nxt;

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo,
                                      input logic [31:0] hi);
        return (a >= lo) && (a <= hi);
    endfunction : in_range

    function automatic logic [31:0] apply_strb(input logic [31:0] old,
                                               input logic [31:0] wd, input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (strb[b]) begin
                r[8*b +: 8] = wd[8*b +: 8];
            end
        end
        return r;
    endfunction : apply_strb

    // Returns {mapped, read data}; reserved bits read as zero
    function automatic logic [32:0] reg_read(input secmon_st_type s, input logic [31:0] a);
        logic [32:0] r;
        r = {1'b1, 32'h0000_0000};
        if (a[31:8] != 24'h000000) begin
            r[32] = 1'b0;
        end else if (a[7:5] == OFF_PART_PAGE) begin
            r[31:0] = a[2] ? s.limit[a[4:3]] : s.base[a[4:3]];
        end else begin
            case ({a[7:2], 2'b00})
                OFF_CTRL: r[1:0] = s.ctrl;
                OFF_STAT: r[ST_W-1:0] = s.stat;
                OFF_BOOT: r[1:0] = {s.boot_lock, s.boot_flash};
                OFF_LIFE: r[1:0] = {s.lc == LC_TEST, s.lc == LC_NORMAL};
                OFF_ATTR: r[2*PART_N-1:0] = s.attr;
                default: r[32] = 1'b0;
            endcase
        end
        return r;
    endfunction : reg_read

    // ----------------------------------------------------------------
    // Pad filters
    // ----------------------------------------------------------------
    secmon_filt #(.INIT(1'b1)) u_filt_rst (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_raw(i_rst_pad_n),
        .o_clean(o_rst_pad_filt_n)
    );

    secmon_filt #(.INIT(1'b0)) u_filt_clk (
        .i_clk_sys(i_clk_sys),
        .i_reset(i_reset),
        .i_raw(i_clk_pad),
        .o_clean(o_clk_pad_filt)
    );

    // ----------------------------------------------------------------
    // Next-state logic
    // ----------------------------------------------------------------
    logic aw_rdy, w_rdy, ar_rdy;
    logic [ST_W-1:0] set_bits, clr_bits;
    logic tamper, det_evt, acc_evt;
    logic in_rom, in_fl, in_ram, in_trace, user_ok, wr_block, part_hit;
    logic a_inval, a_prohib, a_flwp;
    logic [32:0] wr_look, rd_look;
    logic [31:0] wr_val, clr_word;

    assign aw_rdy = !st_r.aw_got && !st_r.bvalid;
    assign w_rdy = !st_r.w_got && !st_r.bvalid;
    assign ar_rdy = !st_r.rvalid;

    always_comb begin
        st_nxt = st_r;
        st_nxt.test_rej = 1'b0;
        st_nxt.nv_wr = 1'b0;
        st_nxt.acc.done = 1'b0;
        clr_bits = '0;

        // Detectors log regardless of any setting; a broken rail pair is tamper
        tamper = (i_det ^ i_det_n) != {DET_N{1'b1}};
        set_bits = '0;
        set_bits[DET_N-1:0] = i_det;
        set_bits[ST_SHIELD] = i_shield_alarm;
        set_bits[ST_LIFE] = tamper;

        // Access check against map, partitions and lifecycle
        in_rom = in_range(i_acc.addr, ROM_LO, ROM_HI);
        in_fl = in_range(i_acc.addr, FLASH_LO, FLASH_HI);
        in_ram = in_range(i_acc.addr, RAM_LO, RAM_HI);
        in_trace = in_range(i_acc.addr, TRACE_LO, TRACE_HI);
        user_ok = 1'b0;
        wr_block = 1'b0;
        part_hit = 1'b0;
        for (int i = 0; i < PART_N; i++) begin
            part_hit = ((i < FLASH_PARTS) ? in_fl : in_ram)
                       && in_range(i_acc.addr, st_r.base[i], st_r.limit[i]);
            if (part_hit && st_r.attr[2*i+ATTR_USER]
                    && (!i_acc.write || st_r.attr[2*i+ATTR_WR])) begin
                user_ok = 1'b1;
            end
            if (part_hit && in_fl && !st_r.attr[2*i+ATTR_WR]) begin
                wr_block = 1'b1;
            end
        end
        a_inval = !(in_rom || in_fl || in_ram);
        a_prohib = !a_inval && ((in_rom && i_acc.write)
                   || (i_acc.user && !in_rom && !user_ok));
        a_flwp = in_fl && i_acc.write
                 && (wr_block || (in_trace && st_r.lc == LC_NORMAL));
        if (i_acc.valid) begin
            st_nxt.acc.done = 1'b1;
            st_nxt.acc.ok = !(a_inval || a_prohib || a_flwp);
            st_nxt.acc.trap = a_prohib || a_flwp;
            st_nxt.acc.inval = a_inval;
            set_bits[ST_INVAL] = a_inval;
            set_bits[ST_PROHIB] = a_prohib;
            set_bits[ST_FLWP] = a_flwp;
        end
        acc_evt = |set_bits[ST_FLWP:ST_INVAL];
        det_evt = |set_bits[ST_LIFE:0];

        // Lifecycle; a normal-mode mark in non-volatile memory always wins
        case (st_r.lc)
            LC_LOAD: begin
                st_nxt.lc = LC_LOCKED;
            end
            LC_LOCKED: begin
                if (i_test.valid && i_test.pw == TEST_PASSWORD) begin
                    st_nxt.lc = LC_TEST;
                end else if (i_test.valid) begin
                    st_nxt.test_rej = 1'b1;
                end
            end
            LC_TEST: begin
                st_nxt.lc = LC_TEST;
            end
            LC_NORMAL: begin
                st_nxt.test_rej = i_test.valid;
            end
            default: begin
                st_nxt.lc = LC_NORMAL;
            end
        endcase
        if (i_nv_normal) begin
            st_nxt.lc = LC_NORMAL;
        end

        // Write channel: address and data in either order
        if (i_axi.awvalid && aw_rdy) begin
            st_nxt.aw_got = 1'b1;
            st_nxt.aw_addr = i_axi.awaddr;
            st_nxt.aw_priv = i_axi.awprot[0];
        end
        if (i_axi.wvalid && w_rdy) begin
            st_nxt.w_got = 1'b1;
            st_nxt.wdata = i_axi.wdata;
            st_nxt.wstrb = i_axi.wstrb;
        end
        wr_look = reg_read(st_r, st_r.aw_addr);
        wr_val = apply_strb(wr_look[31:0], st_r.wdata, st_r.wstrb);
        clr_word = apply_strb(32'h0000_0000, st_r.wdata, st_r.wstrb);
        if (st_r.aw_got && st_r.w_got) begin
            st_nxt.aw_got = 1'b0;
            st_nxt.w_got = 1'b0;
            st_nxt.bvalid = 1'b1;
            st_nxt.bresp = RESP_OKAY;
            if (!wr_look[32]) begin
                st_nxt.bresp = RESP_DECERR;
            end else if (!st_r.aw_priv) begin
                st_nxt.bresp = RESP_SLVERR;
            end else if (st_r.aw_addr[7:5] == OFF_PART_PAGE) begin
                if (st_r.aw_addr[2]) begin
                    st_nxt.limit[st_r.aw_addr[4:3]] = wr_val;
                end else begin
                    st_nxt.base[st_r.aw_addr[4:3]] = wr_val;
                end
            end else begin
                case ({st_r.aw_addr[7:2], 2'b00})
                    OFF_CTRL: st_nxt.ctrl = wr_val[1:0];
                    OFF_STAT: clr_bits = clr_word[ST_W-1:0];
                    OFF_BOOT: begin
                        if (st_r.boot_lock) begin
                            st_nxt.bresp = RESP_SLVERR;
                        end else begin
                            st_nxt.boot_flash = wr_val[BOOT_SRC];
                            st_nxt.boot_lock = wr_val[BOOT_LOCK];
                        end
                    end
                    OFF_LIFE: begin
                        if (wr_val[LIFE_NORMAL] && st_r.lc == LC_TEST) begin
                            st_nxt.lc = LC_NORMAL;
                            st_nxt.nv_wr = 1'b1;
                        end
                    end
                    OFF_ATTR: st_nxt.attr = wr_val[2*PART_N-1:0];
                    default: st_nxt.bresp = RESP_DECERR;
                endcase
            end
        end
        if (st_r.bvalid && i_axi.bready) begin
            st_nxt.bvalid = 1'b0;
        end

        // Read channel; reads need no privilege and have no side effect
        rd_look = reg_read(st_r, i_axi.araddr);
        if (st_r.rvalid && i_axi.rready) begin
            st_nxt.rvalid = 1'b0;
        end
        if (i_axi.arvalid && ar_rdy) begin
            st_nxt.rvalid = 1'b1;
            st_nxt.rdata = rd_look[32] ? rd_look[31:0] : 32'h0000_0000;
            st_nxt.rresp = rd_look[32] ? RESP_OKAY : RESP_DECERR;
        end

        // Set wins over a clear landing in the same cycle
        st_nxt.stat = (st_r.stat & ~clr_bits) | set_bits;

        // Reaction: hold chip reset for a fixed time, else flag; with CTRL_DET_RST clear a shield alarm also raises halt IRQ
        if ((det_evt && st_r.ctrl[CTRL_DET_RST])
                || (acc_evt && st_r.ctrl[CTRL_ACC_RST])) begin
            st_nxt.rst_cnt = RST_CNT_W'(RST_HOLD_CYC);
        end else if (st_r.rst_cnt != '0) begin
            st_nxt.rst_cnt = st_r.rst_cnt - 1'b1;
        end
        st_nxt.halt = !st_r.ctrl[CTRL_DET_RST] && st_nxt.stat[ST_SHIELD];
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            st_r <= ST_RST;
        end else begin
            st_r <= st_nxt;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    assign o_axi = '{awready: aw_rdy, wready: w_rdy, bvalid: st_r.bvalid,
                     bresp: st_r.bresp, arready: ar_rdy, rvalid: st_r.rvalid,
                     rdata: st_r.rdata, rresp: st_r.rresp};
    assign o_acc = st_r.acc;
    assign o_nv_normal_wr = st_r.nv_wr;
    assign o_test_mode = st_r.lc == LC_TEST;
    assign o_functest_en = st_r.lc == LC_TEST;
    assign o_test_rej = st_r.test_rej;
    assign o_chip_reset = st_r.rst_cnt != '0;
    assign o_halt_irq = st_r.halt;
    assign o_boot_flash = st_r.boot_flash;

endmodule : secmon_top

// *** rtl/secmon_pkg.sv ***
// Shared constants and types for the security monitor and lifecycle guard.
// Assumes a 50 MHz system clock and a 32-bit AXI4-Lite register bus.
package secmon_pkg;

    // ----------------------------------------------------------------
    // Sizes and timing
    // ----------------------------------------------------------------
    localparam int DET_N = 8;
    localparam int PART_N = 4;
    localparam int FLASH_PARTS = 2;
    localparam int CLK_PERIOD_NS = 20;
    localparam int FILT_NS = 100;
    localparam int FILT_CYC = (FILT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FILT_CNT_W = 3;
    localparam int RST_HOLD_NS = 320;
    localparam int RST_HOLD_CYC = RST_HOLD_NS / CLK_PERIOD_NS;
    localparam int RST_CNT_W = 5;

    // ----------------------------------------------------------------
    // Register offsets and fields
    // ----------------------------------------------------------------
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_STAT = 8'h04;
    localparam logic [7:0] OFF_BOOT = 8'h08;
    localparam logic [7:0] OFF_LIFE = 8'h0C;
    localparam logic [7:0] OFF_ATTR = 8'h10;
    // Byte addresses 0x20..0x3F: base at 0x20+8*i, limit at 0x24+8*i
    localparam logic [2:0] OFF_PART_PAGE = 3'h1;

    localparam int CTRL_DET_RST = 0;
    localparam int CTRL_ACC_RST = 1;
    localparam int ST_SHIELD = 8;
    localparam int ST_LIFE = 9;
    localparam int ST_INVAL = 10;
    localparam int ST_PROHIB = 11;
    localparam int ST_FLWP = 12;
    localparam int ST_W = 13;
    localparam int BOOT_SRC = 0;
    localparam int BOOT_LOCK = 1;
    localparam int LIFE_NORMAL = 0;
    localparam int ATTR_USER = 0;
    localparam int ATTR_WR = 1;

    localparam logic [1:0] CTRL_RST = 2'h1;
    localparam logic [ST_W-1:0] STAT_RST = 13'h0000;
    localparam logic [2*PART_N-1:0] ATTR_RST = 8'h00;
    localparam logic [31:0] PART_RST = 32'h0000_0000;

    // ----------------------------------------------------------------
    // Memory map seen by the access checker
    // ----------------------------------------------------------------
    localparam logic [31:0] ROM_LO = 32'h0000_0000;
    localparam logic [31:0] ROM_HI = 32'h0000_FFFF;
    localparam logic [31:0] FLASH_LO = 32'h0010_0000;
    localparam logic [31:0] FLASH_HI = 32'h001F_FFFF;
    localparam logic [31:0] TRACE_LO = 32'h001F_F000;
    localparam logic [31:0] TRACE_HI = 32'h001F_FFFF;
    localparam logic [31:0] RAM_LO = 32'h0020_0000;
    localparam logic [31:0] RAM_HI = 32'h0020_FFFF;

    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [1:0] {LC_LOAD, LC_LOCKED, LC_TEST, LC_NORMAL} secmon_lc_type;

    typedef struct packed {
        logic awvalid; logic [31:0] awaddr; logic [2:0] awprot;
        logic wvalid; logic [31:0] wdata; logic [3:0] wstrb;
        logic bready;
        logic arvalid; logic [31:0] araddr; logic [2:0] arprot;
        logic rready;
    } secmon_axi_req_type;

    typedef struct packed {
        logic awready; logic wready;
        logic bvalid; logic [1:0] bresp;
        logic arready;
        logic rvalid; logic [31:0] rdata; logic [1:0] rresp;
    } secmon_axi_rsp_type;

    typedef struct packed {
        logic valid; logic write; logic user; logic [31:0] addr;
    } secmon_acc_req_type;

    typedef struct packed {
        logic done; logic ok; logic trap; logic inval;
    } secmon_acc_rsp_type;

    typedef struct packed {
        logic valid; logic [31:0] pw;
    } secmon_test_req_type;

    typedef struct packed {
        logic clean; logic [FILT_CNT_W-1:0] cnt;
    } secmon_filt_st_type;

endpackage : secmon_pkg

// *** rtl/secmon_filt.sv ***
// Glitch and high-frequency filter for one external pad signal.
// Assumes the pad level is already synchronous to i_clk_sys.
`timescale 1ns/1ns
module secmon_filt
    import secmon_pkg::*;
#(
    parameter logic INIT = 1'b0
) (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // Pad in, clean level out
    input wire logic i_raw,
    output logic o_clean
);

    secmon_filt_st_type st_r;
    secmon_filt_st_type st_nxt;

    // ----------------------------------------------------------------
    // Accept a new level only after it has stood FILT_CYC samples
    // ----------------------------------------------------------------
    always_comb begin
        st_nxt = st_r;
        if (i_raw == st_r.clean) begin
            st_nxt.cnt = '0;
        end else if (st_r.cnt == FILT_CNT_W'(FILT_CYC - 1)) begin
            st_nxt.clean = i_raw;
            st_nxt.cnt = '0;
        end else begin
            st_nxt.cnt = st_r.cnt + 1'b1;
        end
    end

    always_ff @(posedge i_clk_sys) begin
        if (i_reset) begin
            st_r <= '{clean: INIT, cnt: '0};
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_clean = st_r.clean;

endmodule : secmon_filt

// *** verif/secmon_checker.sv ***
// Port assertions for the security monitor.
// Assumes a bind onto secmon_top; one clock, synchronous reset.
`timescale 1ns/1ns
module secmon_checker
    import secmon_pkg::*;
(
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_reset,
    // Watched ports
    input wire secmon_axi_rsp_type o_axi,
    input wire secmon_acc_req_type i_acc,
    input wire secmon_acc_rsp_type o_acc,
    input wire secmon_test_req_type i_test,
    input wire logic i_nv_normal,
    input wire logic i_clk_pad,
    input wire logic o_clk_pad_filt,
    input wire logic o_chip_reset,
    input wire logic o_test_mode,
    input wire logic o_functest_en,
    input wire logic o_test_rej
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (i_reset);
    property p_acc_done; i_acc.valid |=> o_acc.done; endproperty
    a_acc_done: assert property (p_acc_done) else $error("no access answer");
    property p_done_pulse; !i_acc.valid |=> !o_acc.done; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("stray answer");
    property p_acc_excl; o_acc.done |-> (o_acc.ok != (o_acc.trap || o_acc.inval)); endproperty
    a_acc_excl: assert property (p_acc_excl) else $error("trapped access passed");
    property p_chip_rst; $rose(o_chip_reset) |-> o_chip_reset [*8]; endproperty
    a_chip_rst: assert property (p_chip_rst) else $error("chip reset too short");
    property p_functest; o_functest_en == o_test_mode; endproperty
    a_functest: assert property (p_functest) else $error("functest outside test");
    property p_no_test; i_nv_normal |=> !o_test_mode; endproperty
    a_no_test: assert property (p_no_test) else $error("test mode after normal");
    property p_rej; i_nv_normal ##1 (i_nv_normal && i_test.valid) |=> o_test_rej; endproperty
    a_rej: assert property (p_rej) else $error("test command not refused");
    property p_filt;
        $changed(o_clk_pad_filt) |->
            $past(i_clk_pad) == o_clk_pad_filt && $past(i_clk_pad, 2) == o_clk_pad_filt;
    endproperty
    a_filt: assert property (p_filt) else $error("clock filter passed glitch");
    property p_b_block; o_axi.bvalid |-> !o_axi.awready && !o_axi.wready; endproperty
    a_b_block: assert property (p_b_block) else $error("write taken during answer");
endmodule : secmon_checker

// *** verif/secmon_cpu_model.sv ***
// Processor-side master model for the register bus.
// Assumes an AXI4-Lite slave; the bench's own timeout ends a hang.
`timescale 1ns/1ns
module secmon_cpu_model
    import secmon_pkg::*;
(
    // Clock
    input wire logic i_clk_sys,
    // Register bus
    input wire secmon_axi_rsp_type i_axi_rsp,
    output secmon_axi_req_type o_axi_req
);
    initial o_axi_req = '0;
    // Released lines show the inverse so a stale value never looks valid
    task automatic write_reg(input logic [31:0] a, v, input logic [2:0] p, output logic [1:0] r);
        logic aw, w;
        {aw, w} = 2'b00;
        @(posedge i_clk_sys);
        o_axi_req <= '{1'b1, a, p, 1'b1, v, 4'hF, 1'b1, 1'b0, ~a, 3'h0, 1'b0};
        do begin
            @(posedge i_clk_sys);
            if (o_axi_req.awvalid && i_axi_rsp.awready) begin
                aw = 1'b1;
                o_axi_req.awvalid <= 1'b0;
                o_axi_req.awaddr <= ~a;
            end
            if (o_axi_req.wvalid && i_axi_rsp.wready) begin
                w = 1'b1;
                o_axi_req.wvalid <= 1'b0;
                o_axi_req.wdata <= ~v;
            end
        end while (!(aw && w));
        do @(posedge i_clk_sys); while (i_axi_rsp.bvalid !== 1'b1);
        r = i_axi_rsp.bresp;
        o_axi_req.bready <= 1'b0;
    endtask : write_reg
    task automatic read_reg(input logic [31:0] a, output logic [31:0] v, output logic [1:0] r);
        @(posedge i_clk_sys);
        o_axi_req <= '{1'b0, ~a, 3'h0, 1'b0, ~a, 4'h0, 1'b0, 1'b1, a, 3'h1, 1'b1};
        do @(posedge i_clk_sys); while (i_axi_rsp.arready !== 1'b1);
        o_axi_req.arvalid <= 1'b0;
        o_axi_req.araddr <= ~a;
        do @(posedge i_clk_sys); while (i_axi_rsp.rvalid !== 1'b1);
        v = i_axi_rsp.rdata;
        r = i_axi_rsp.rresp;
        o_axi_req.rready <= 1'b0;
    endtask : read_reg
endmodule : secmon_cpu_model

// *** verif/test_security_monitor_and_lifecycle_guard.sv ***
// Self-checking bench for secmon_top with a bus master model.
// Assumes a 50 MHz clock and a 2-cycle synchronous reset.
`timescale 1ns/1ns
module test_security_monitor_and_lifecycle_guard
    import secmon_pkg::*;
;
    // Value is arbitrary
    localparam logic [31:0] PW = 32'h5EC0_0A11;
    logic i_clk_sys = 1'b0, i_reset = 1'b1, i_shield_alarm = 1'b0, i_nv_normal = 1'b0;
    logic i_rst_pad_n = 1'b1, i_clk_pad = 1'b0, saw_wr = 1'b0;
    logic [DET_N-1:0] i_det = '0, i_det_n = '1;
    secmon_axi_req_type i_axi;
    secmon_axi_rsp_type o_axi;
    secmon_acc_req_type i_acc = '0;
    secmon_acc_rsp_type o_acc;
    secmon_test_req_type i_test = '0;
    logic o_rst_pad_filt_n, o_clk_pad_filt, o_nv_normal_wr, o_test_mode, o_functest_en;
    logic o_test_rej, o_chip_reset, o_halt_irq, o_boot_flash;
    logic [31:0] d;
    logic [1:0] r;
    int n_errors = 0, checks_done = 0, cyc = 0;
    secmon_top #(.TEST_PASSWORD(PW)) u_secmon_top (.i_clk_sys, .i_reset, .i_axi, .o_axi,
        .i_det, .i_det_n, .i_shield_alarm, .i_rst_pad_n, .i_clk_pad, .o_rst_pad_filt_n,
        .o_clk_pad_filt, .i_acc, .o_acc, .i_nv_normal, .i_test, .o_nv_normal_wr, .o_test_mode,
        .o_functest_en, .o_test_rej, .o_chip_reset, .o_halt_irq, .o_boot_flash);
    secmon_cpu_model u_secmon_cpu_model (.i_clk_sys, .i_axi_rsp(o_axi), .o_axi_req(i_axi));
    initial forever #10 i_clk_sys = ~i_clk_sys;
    always @(posedge i_clk_sys) begin
        cyc++;
        saw_wr = saw_wr | (o_nv_normal_wr === 1'b1);
        if (cyc == 20000) begin
            n_errors++;
            finish_test();
        end
    end
    task automatic chk(input logic [31:0] g, e);
        checks_done++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %0t got %h want %h", $time, g, e);
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
        u_secmon_cpu_model.write_reg({24'h0, a}, v, 3'h1, r);
        chk({30'h0, r}, {30'h0, e});
    endtask : wr
    task automatic rdc(input logic [7:0] a, input logic [31:0] e);
        u_secmon_cpu_model.read_reg({24'h0, a}, d, r);
        chk(d, e);
    endtask : rdc
    // Drives one request for a cycle and looks at the registered answer
    task automatic acc(input logic w, u, input logic [31:0] a, input logic [3:0] e);
        @(posedge i_clk_sys);
        i_acc <= '{1'b1, w, u, a};
        @(posedge i_clk_sys);
        i_acc.valid <= 1'b0;
        @(negedge i_clk_sys);
        chk(32'(o_acc), 32'(e));
    endtask : acc
    task automatic tcmd(input logic [31:0] pw, input logic [1:0] e);
        @(posedge i_clk_sys);
        i_test <= '{1'b1, pw};
        @(posedge i_clk_sys);
        i_test.valid <= 1'b0;
        @(negedge i_clk_sys);
        chk(32'({o_test_rej, o_test_mode}), 32'(e));
    endtask : tcmd
    task automatic t_regs;
        rdc(OFF_CTRL, 32'h1);
        rdc(OFF_STAT, 32'h0);
        rdc(OFF_ATTR, 32'h0);
        rdc(8'h3C, 32'h0);
        wr(8'h14, 32'h1, RESP_DECERR);
        u_secmon_cpu_model.write_reg(32'h0, 32'h0, 3'h0, r);
        chk({30'h0, r}, {30'h0, RESP_SLVERR});
        rdc(OFF_CTRL, 32'h1);
    endtask : t_regs
    task automatic t_det(input logic [31:0] c, input logic [7:0] ev, input logic [31:0] st);
        wr(OFF_CTRL, c, RESP_OKAY);
        @(posedge i_clk_sys);
        i_det <= ev;
        i_det_n <= ~ev & 8'hFD;
        i_shield_alarm <= 1'b1;
        @(posedge i_clk_sys);
        {i_det, i_det_n, i_shield_alarm} <= {8'h00, 8'hFF, 1'b0};
        repeat (3) @(negedge i_clk_sys);
        chk(32'(o_chip_reset), c);
        rdc(OFF_STAT, st);
        chk(32'(o_halt_irq), ~c & 32'h1);
        wr(OFF_STAT, st, RESP_OKAY);
        rdc(OFF_STAT, 32'h0);
    endtask : t_det
    task automatic t_acc;
        wr(8'h20, 32'h0010_0000, RESP_OKAY);
        wr(8'h24, 32'h0010_FFFF, RESP_OKAY);
        wr(OFF_ATTR, 32'h1, RESP_OKAY);
        acc(1'b0, 1'b1, 32'h0010_0010, 4'hC);
        acc(1'b1, 1'b1, 32'h0010_0010, 4'hA);
        acc(1'b0, 1'b1, 32'h0020_0000, 4'hA);
        acc(1'b1, 1'b0, 32'h0000_0100, 4'hA);
        acc(1'b0, 1'b0, 32'h0030_0000, 4'h9);
        rdc(OFF_STAT, 32'h1C00);
        wr(OFF_CTRL, 32'h2, RESP_OKAY);
        acc(1'b0, 1'b0, 32'h0030_0000, 4'h9);
        chk(32'(o_chip_reset), 32'h1);
        wr(OFF_STAT, 32'h1C00, RESP_OKAY);
    endtask : t_acc
    task automatic t_boot;
        wr(OFF_BOOT, 32'h1, RESP_OKAY);
        wr(OFF_BOOT, 32'h3, RESP_OKAY);
        wr(OFF_BOOT, 32'h0, RESP_SLVERR);
        chk(32'(o_boot_flash), 32'h1);
    endtask : t_boot
    task automatic t_life;
        tcmd(32'h0, 2'b10);
        tcmd(PW, 2'b01);
        chk(32'(o_functest_en), 32'h1);
        acc(1'b1, 1'b0, 32'h001F_F000, 4'hC);
        wr(OFF_LIFE, 32'h1, RESP_OKAY);
        @(negedge i_clk_sys);
        chk(32'({o_test_mode, o_functest_en, saw_wr}), 32'h1);
        acc(1'b1, 1'b0, 32'h001F_F000, 4'hA);
        @(posedge i_clk_sys) i_nv_normal <= 1'b1;
        tcmd(PW, 2'b10);
        rdc(OFF_LIFE, 32'h1);
    endtask : t_life
    task automatic t_filt;
        @(posedge i_clk_sys);
        {i_clk_pad, i_rst_pad_n} <= 2'b10;
        repeat (3) @(posedge i_clk_sys);
        {i_clk_pad, i_rst_pad_n} <= 2'b01;
        repeat (6) @(negedge i_clk_sys);
        chk(32'({o_clk_pad_filt, o_rst_pad_filt_n}), 32'h1);
        @(posedge i_clk_sys);
        {i_clk_pad, i_rst_pad_n} <= 2'b10;
        repeat (8) @(negedge i_clk_sys);
        chk(32'({o_clk_pad_filt, o_rst_pad_filt_n}), 32'h2);
        @(posedge i_clk_sys);
        i_rst_pad_n <= 1'b1;
    endtask : t_filt
    task automatic finish_test;
        if (n_errors == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : finish_test
    initial begin
        repeat (2) @(posedge i_clk_sys);
        i_reset <= 1'b0;
        t_regs();
        t_filt();
        t_det(32'h0, 8'h81, 32'h381);
        t_det(32'h1, 8'h10, 32'h310);
        t_acc();
        t_boot();
        t_life();
        finish_test();
    end
endmodule : test_security_monitor_and_lifecycle_guard
bind secmon_top secmon_checker u_secmon_checker (.i_clk_sys, .i_reset, .o_axi, .i_acc, .o_acc,
    .i_test, .i_nv_normal, .i_clk_pad, .o_clk_pad_filt, .o_chip_reset, .o_test_mode,
    .o_functest_en, .o_test_rej);
